// File: dv/sfpm_host_model.sv
`default_nettype none
// ***
// Host controller model.
// ***
module sfpm_host (
  input  wire logic       clock,
  output logic            sck = 1'h0,
  output logic            cs_n = 1'h1,
  output logic      [3:0] io_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       en = 1'h0;
  logic [3:0] v  = 4'h0;
  // Released lanes 0 and 1 have no pull, so they show the inverse of the last level.
  assign io_d = en ? v : {2'h3, ~v[1:0]};
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Every owned lane gets a defined level, so write protect never floats.
  task automatic drive(input logic [3:0] d, input logic sel, input logic e);
    en = e;
    v = d;
    cs_n = !sel;
    hold(4);
  endtask
  task automatic clocks(input int n);
    repeat (n) begin
      sck = 1'h1;
      hold(8);
      sck = 1'h0;
      hold(8);
    end
  endtask
endmodule
`default_nettype wire

// File: dv/sfpm_pin_role_mux_monitor.sv
`default_nettype none
// ***
// Pin role checks.
// ***
module sfpm_mon (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [1:0] cmd_width,
  input wire logic       out_phase,
  input wire logic       reg_write_req,
  input wire logic       sck_fall,
  input wire logic       select_q,
  input wire logic [3:0] io_oe,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] nonvolatile_status_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic       write_protect_active,
  input wire logic       reg_write_allow,
  input wire logic       reset_pin_role,
  input wire logic       reset_detect
);
  wire logic q  = volatile_config_one[1];
  wire logic wd = nonvolatile_status_one[7];
  wire logic re = volatile_config_two[5];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_r1; io_oe[0] |-> $past(cmd_width) != 2'h0; endproperty
  a_r1: assert property (p_r1) else $error("lane 0 driven in single");
  property p_r2; sck_fall && out_phase |=> io_oe[1]; endproperty
  a_r2: assert property (p_r2) else $error("lane 1 not driven");
  property p_r3; write_protect_active == (!q && wd); endproperty
  a_r3: assert property (p_r3) else $error("protect role wrong");
  property p_r4; q |-> !write_protect_active; endproperty
  a_r4: assert property (p_r4) else $error("protect in quad");
  property p_r6; q && select_q |-> !reset_pin_role; endproperty
  a_r6: assert property (p_r6) else $error("lane 3 seen as reset");
  property p_r7; reset_pin_role == (re && (!q || !select_q)); endproperty
  a_r7: assert property (p_r7) else $error("reset role wrong");
  property p_r8; reg_write_req && !write_protect_active |=> reg_write_allow; endproperty
  a_r8: assert property (p_r8) else $error("write lost");
  property p_r9; reset_detect |-> !select_q && reset_pin_role; endproperty
  a_r9: assert property (p_r9) else $error("reset while selected");
  c_rst: cover property (reset_detect);
  c_wr: cover property (reg_write_allow);
  c_out: cover property (io_oe[1]);
endmodule
bind sfpm_pin_role_mux sfpm_mon sfpm_mon_inst (.*);
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
// ***
// Pin role bench.
// ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, rst = 1'h1, op = 1'h0, req = 1'h0, tgt = 1'h1;
  logic [3:0] co = 4'h0;
  logic [7:0] c1 = 8'h00, s1 = 8'h00, c2 = 8'h00;
  logic [1:0] w = 2'h0;
  wire logic sck, cs_n, rise, fall, sel, wpa, allow, role, det;
  wire logic [3:0] io_d, io_out, io_oe, core_in;
  wire logic [3:0] io_in = (io_oe & io_out) | (~io_oe & io_d);
  int fail_count = 0, n_compared = 0, n_det = 0, k;
  always #5 clock = ~clock;
  always @(negedge clock) if (det === 1'h1) n_det++;
  sfpm_host sfpm_host_inst (.clock(clock), .sck(sck), .cs_n(cs_n), .io_d(io_d));
  sfpm_pin_role_mux #(.RESET_PULSE(8)) sfpm_pin_role_mux_inst (.clock(clock), .rst(rst),
    .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .volatile_config_one(c1), .nonvolatile_status_one(s1), .volatile_config_two(c2),
    .cmd_width(w), .out_phase(op), .core_out(co), .reg_write_req(req),
    .reg_write_protected_target(tgt), .core_in(core_in), .sck_rise(rise), .sck_fall(fall),
    .select_q(sel), .write_protect_active(wpa), .reg_write_allow(allow),
    .reset_pin_role(role), .reset_detect(det));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_roles;
    for (k = 0; k < 16; k++) begin
      c1[1] = k[0];
      s1[7] = k[1];
      c2[5] = k[2];
      sfpm_host_inst.drive(4'hF, k[3], 1'h1);
      check({3'h0, wpa}, {3'h0, !k[0] && k[1]});
      check({3'h0, role}, {3'h0, k[2] && !(k[0] && k[3])});
    end
    $display("roles done");
  endtask
  task automatic t_lanes;
    w = 2'h2;
    sfpm_host_inst.drive(4'hA, 1'h1, 1'h1);
    sfpm_host_inst.clocks(2);
    check(core_in, 4'hA);
    w = 2'h0;
    op = 1'h1;
    co = 4'h6;
    sfpm_host_inst.drive(4'h5, 1'h1, 1'h0);
    sfpm_host_inst.clocks(1);
    check(io_oe, 4'h2);
    check(io_out, 4'h6);
    op = 1'h0;
    $display("lanes done");
  endtask
  task automatic t_write;
    c1[1] = 1'h0;
    for (k = 0; k < 4; k++) begin
      s1[7] = (k != 2);
      tgt = (k != 3);
      sfpm_host_inst.drive({1'h1, k == 1, 2'h3}, 1'h1, 1'h1);
      req = 1'h1;
      @(negedge clock);
      req = 1'h0;
      check({3'h0, allow}, {3'h0, k != 0});
    end
    $display("write done");
  endtask
  task automatic t_reset;
    for (k = 0; k < 2; k++) begin
      n_det = 0;
      sfpm_host_inst.drive(4'h7, 1'h0, 1'h1);
      sfpm_host_inst.hold(k * 12);
      sfpm_host_inst.drive(4'hF, 1'h0, 1'h1);
      check(n_det[3:0], k[3:0]);
    end
    $display("reset done");
  endtask
  initial begin
    sfpm_host_inst.hold(4);
    rst = 1'h0;
    sfpm_host_inst.hold(3);
    t_roles;
    t_lanes;
    t_write;
    t_reset;
    print_verdict;
  end
  // The whole run needs under two hundred cycles, so this leaves wide margin.
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
endmodule
`default_nettype wire

// File: logic/sfpm_pin_role_mux.sv
// What this block does
// - First pin: serial input, else lane 0.
// - Second pin: serial output, else lane 1.
// - Third pin write-protect when quad off, disable set.
// - Quad on: third pin is lane 2.
// - Fourth pin lane 3: quad on, selected.
// - Reset enabled: fourth pin is reset input otherwise.
// - Protected register writes silently ignored, no error.
// - Reset needs select high, pin low, minimum time.
// - Reset disabled: fourth pin ignored outside quad.
`default_nettype none
module sfpm_pin_role_mux #(
  parameter int RESET_PULSE = sfpm_pkg::RESET_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Link pins from the host
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  // Configuration and status bits
  input  wire logic [sfpm_pkg::CFG_WIDTH-1:0] volatile_config_one,
  input  wire logic [sfpm_pkg::CFG_WIDTH-1:0] nonvolatile_status_one,
  input  wire logic [sfpm_pkg::CFG_WIDTH-1:0] volatile_config_two,
  // Command core side
  input  wire logic [1:0] cmd_width,
  input  wire logic       out_phase,
  input  wire logic [3:0] core_out,
  input  wire logic       reg_write_req,
  input  wire logic       reg_write_protected_target,
  output logic      [3:0] core_in,
  output logic            sck_rise,
  output logic            sck_fall,
  output logic            select_q,
  output logic            write_protect_active,
  output logic            reg_write_allow,
  output logic            reset_pin_role,
  output logic            reset_detect
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] io_s [4];
  logic       sck_prev_q;

  // The serial clock idles low, so its chain starts low and no false edge follows reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_s <= sfpm_pkg::SYNC_INIT;
    end else begin
      sck_s <= {sck_s[0], sck};
    end
  end

  // The select chain starts high, so the block wakes up deselected.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_s <= sfpm_pkg::SYNC_HIGH_INIT;
    end else begin
      cs_s <= {cs_s[0], cs_n};
    end
  end

  // Data pins start high, the level their pull-ups give, so the reset pin does not
  // look low while the chain fills.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        io_s[i] <= sfpm_pkg::SYNC_HIGH_INIT;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        io_s[i] <= {io_s[i][0], io_in[i]};
      end
    end
  end

  // Edges are found on the second stage only, so the first stage stays a clean flop.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s[1];
    end
  end

  logic cs_low;
  logic quad_en;
  logic lane3_role;
  assign cs_low     = ~cs_s[1];
  assign quad_en    = volatile_config_one[sfpm_pkg::QUAD_ENABLE_BIT];
  assign sck_rise   = cs_low & sck_s[1] & ~sck_prev_q;
  assign sck_fall   = cs_low & ~sck_s[1] & sck_prev_q;
  assign select_q   = cs_low;
  assign lane3_role = quad_en & cs_low;

  // ****************************************
  // Lane decoding
  // ****************************************
  // Tells whether a lane carries data in one direction for the running command.
  // The first pin only listens in single-bit commands and the second only talks.
  function automatic logic lane_live(
    input logic [1:0] width,
    input logic       quad_on,
    input logic       lane3_owned,
    input logic       is_tx,
    input int         lane
  );
    logic wide;
    logic quad;
    wide = (width == sfpm_pkg::WIDTH_DUAL) || (width == sfpm_pkg::WIDTH_QUAD);
    quad = quad_on && (width == sfpm_pkg::WIDTH_QUAD);
    if (lane == 0) begin
      return is_tx ? wide : 1'b1;
    end else if (lane == 1) begin
      return is_tx ? 1'b1 : wide;
    end else if (lane == 2) begin
      return quad;
    end else begin
      return quad && lane3_owned;
    end
  endfunction

  logic [3:0] tx_live;
  logic [3:0] rx_live;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tx_live[i] = lane_live(cmd_width, quad_en, lane3_role, 1'b1, i);
      rx_live[i] = lane_live(cmd_width, quad_en, lane3_role, 1'b0, i);
    end
  end

  // ****************************************
  // Lane roles and drive
  // ****************************************
  // Output data is registered and changes one clock after sck_fall, three clocks after the serial clock pin falls.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      io_out <= 4'h0;
    end else if (!cs_low) begin
      io_out <= 4'h0;
    end else if (sck_fall) begin
      io_out <= core_out;
    end
  end

  // Drive is dropped a clock after deselect, so the host may take the pins back.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      io_oe <= 4'h0;
    end else if (!cs_low) begin
      io_oe <= 4'h0;
    end else if (sck_fall) begin
      io_oe[0] <= out_phase & tx_live[0];
      io_oe[1] <= out_phase & tx_live[1];
      io_oe[2] <= out_phase & tx_live[2];
      io_oe[3] <= out_phase & tx_live[3];
    end
  end

  // Single-bit commands only see the first pin; wide commands gather every live lane.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_in <= 4'h0;
    end else if (sck_rise) begin
      core_in[0] <= rx_live[0] & io_s[0][1];
      core_in[1] <= rx_live[1] & io_s[1][1];
      core_in[2] <= rx_live[2] & io_s[2][1];
      core_in[3] <= rx_live[3] & io_s[3][1];
    end
  end

  // ****************************************
  // Write protection
  // ****************************************
  // The host must hold the pin at a firm level during register writes, so the
  // synchronised level is trusted as the protect decision.
  assign write_protect_active = ~quad_en &
      nonvolatile_status_one[sfpm_pkg::WRITE_DISABLE_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_write_allow <= 1'b0;
    end else begin
      reg_write_allow <= reg_write_req &
          ~(write_protect_active & ~io_s[2][1] & reg_write_protected_target);
    end
  end

  // ****************************************
  // Hardware reset detection
  // ****************************************
  logic [sfpm_pkg::RESET_COUNT_WIDTH-1:0] rst_cnt_q;
  logic reset_armed;
  assign reset_pin_role = volatile_config_two[sfpm_pkg::RESET_ENABLE_BIT] &
      (~quad_en | ~cs_low);
  assign reset_armed = reset_pin_role & ~cs_low & ~io_s[3][1];

  // The counter stops at the pulse length, so a pin held low for long does not wrap
  // and report again. The pulse length must stay below the counter's range.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= '0;
    end else if (!reset_armed) begin
      rst_cnt_q <= '0;
    end else if (rst_cnt_q != RESET_PULSE[sfpm_pkg::RESET_COUNT_WIDTH-1:0]) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  // The pulse is reported once per low period, so a held pin gives one event.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_detect <= 1'b0;
    end else if (!reset_armed) begin
      reset_detect <= 1'b0;
    end else begin
      reset_detect <= (rst_cnt_q == RESET_PULSE[sfpm_pkg::RESET_COUNT_WIDTH-1:0] - 1'b1);
    end
  end

endmodule
`default_nettype wire

// File: shared/sfpm_pkg.sv
`default_nettype none
package sfpm_pkg;
  // Bit positions in the configuration and status words.
  localparam int QUAD_ENABLE_BIT  = 1;
  localparam int WRITE_DISABLE_BIT = 7;
  localparam int RESET_ENABLE_BIT = 5;
  localparam int CFG_WIDTH = 8;

  // Minimum reset pulse time on the fourth pin, and the clock rate.
  localparam int RESET_PULSE_NS = 200;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_COUNT_WIDTH = 16;

  // Command width codes.
  localparam logic [1:0] WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] WIDTH_DUAL   = 2'h1;
  localparam logic [1:0] WIDTH_QUAD   = 2'h2;

  localparam logic [1:0] SYNC_INIT = 2'h0;
  localparam logic [1:0] SYNC_HIGH_INIT = 2'h3;
endpackage
`default_nettype wire
